/* File: hw/pin_mux_consts.vh */
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define ADDR_ASSIGN 12'h000
`define ADDR_DIVIDER 12'h004
`define ADDR_PORTE 12'h008
`define ADDR_INTCTL 12'h00c
`define ADDR_MODE 12'h010
`define ADDR_TEST 12'h014
// ****************************************
// Assignment register fields
// ****************************************
`define BIT_BUS_ENABLE_SEL 7
`define BIT_TRIM_REF_EN 6
`define BIT_CLOCK_TEST_EN 5
`define BIT_QUEUE_TRACK_EN 4
`define BIT_STROBE_EN 3
`define BIT_RDWR_EN 2
`define BIT_BUS_E_CLOCK_EN 1
`define ASSIGN_RESET 8'h00
// ****************************************
// Interrupt control fields
// ****************************************
`define BIT_IRQ_EDGE 0
`define BIT_IRQ_EN 1
`define INTCTL_RESET 2'h2
// ****************************************
// Reset pin timing (cycles)
// ****************************************
`define RST_DRIVE_CYCLES 5'h10
`define RST_SAMPLE_CYCLES 5'h09
`define DIV_RESET 8'h00
`endif

/* File: hw/bus_control_pin_function_mux.v */
// Functional notes
// - Port E bit 7 reference function drives the slow divider clock.
// - Divider output runs at half input rate after reset, always even duty.
// - Bus enable function overrides reference clock on shared pin.
// - Clearing reference enable stops reference output on the pin.
// - Port E bit 6 shows test clocks when clock test enabled.
// - Test clocks blocked while queue tracking output is enabled.
// - Low byte strobe is XNOR of address bit 0 and size flag.
// - Reset pin bidirectional low; device drives it on watchdog reset.
// - Interrupt request sensed as falling edge or low level.
// - Mode pins sampled during reset choose initial mode.
// - Mode pins become queue tracking outputs or general I/O.
// - Debug pin selects special mode; later debug or tag input.
// - In expanded mode bus enable gates external read drivers.
// - Bus E clock driven out as timing reference.
// - Ports A and B are I/O single chip, bus when expanded.
// - Read/write pin shows direction when expanded, else I/O.
// - Assign register bit controls bus enable; on after reset expanded.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.vh"
module bus_control_pin_function_mux (
  // Clock and reset
  input wire clock_in,
  input wire reset_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // Internal bus sources
  input wire e_clock_in,
  input wire bus_enable_int_in,
  input wire addr0_in,
  input wire access_size_flag_in,
  input wire bus_read_in,
  input wire [15:0] bus_addr_in,
  input wire [15:0] bus_wdata_in,
  input wire test_clock_in,
  input wire [1:0] queue_state_in,
  input wire watchdog_timer_reset_in,
  input wire clock_monitor_reset_in,
  // Pins
  input wire reset_pin_in,
  output reg reset_pin_out,
  output reg reset_pin_oe_out,
  input wire int_request_n_in,
  output reg int_pending_out,
  input wire mode_pin_a_in,
  input wire mode_pin_b_in,
  input wire special_mode_select_n_in,
  output reg tag_high_input_out,
  output reg debug_select_out,
  output reg expanded_mode_out,
  output reg special_mode_out,
  output reg pe7_out,
  output reg pe7_oe_out,
  output reg pe6_out,
  output reg pe6_oe_out,
  output reg [1:0] mode_pins_out,
  output reg mode_pins_oe_out,
  output reg low_byte_strobe_out,
  output reg strobe_oe_out,
  output reg rdwr_out,
  output reg rdwr_oe_out,
  output reg bus_e_clock_out,
  output reg [15:0] port_ab_out,
  output reg [15:0] port_ab_oe_out,
  input wire [15:0] port_ab_in,
  output reg [15:0] bus_rdata_out
);

  reg [7:0] port_e_assign_register;
  reg [7:0] div_r;
  reg [7:0] div_cnt_r;
  reg slow_divider_clock;
  reg [7:0] porte_data_r;
  reg [7:0] porte_dir_r;
  reg [15:0] ab_data_r;
  reg [15:0] ab_dir_r;
  reg [1:0] int_control_register;
  reg irq_d_r;
  reg [2:0] mode_r;
  reg in_reset_r;
  reg [4:0] rst_cnt_r;
  reg rst_drive_r;
  reg [7:0] div_cnt_nxt;

  wire wr_en = psel_in & penable_in & pwrite_in;
  wire expanded = mode_r[0];
  wire bus_enable_select_bit = port_e_assign_register[`BIT_BUS_ENABLE_SEL];
  wire trim_reference_enable = port_e_assign_register[`BIT_TRIM_REF_EN];
  wire clock_test_enable = port_e_assign_register[`BIT_CLOCK_TEST_EN];
  wire queue_track_enable = port_e_assign_register[`BIT_QUEUE_TRACK_EN];
  // Active-low bus enable selected when bit clear, expanded mode only
  wire data_bus_enable_out = expanded & ~bus_enable_select_bit;

  // ****************************************
  // APB register access
  // ****************************************
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      port_e_assign_register <= `ASSIGN_RESET;
      div_r <= `DIV_RESET;
      porte_data_r <= 8'h00;
      porte_dir_r <= 8'h00;
      int_control_register <= `INTCTL_RESET;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end
    else
    begin
      pready_out <= psel_in & ~pready_out;
      pslverr_out <= 1'b0;
      if (psel_in & ~pready_out)
      begin
        prdata_out <= 32'h00000000;
        case (paddr_in)
          `ADDR_ASSIGN: prdata_out[7:0] <= port_e_assign_register;
          `ADDR_DIVIDER: prdata_out[7:0] <= div_r;
          `ADDR_PORTE: prdata_out[15:0] <= {porte_dir_r, porte_data_r};
          `ADDR_INTCTL: prdata_out[1:0] <= int_control_register;
          `ADDR_MODE: prdata_out[2:0] <= mode_r;
          `ADDR_TEST: prdata_out[31:0] <= {ab_dir_r, ab_data_r};
          default: pslverr_out <= 1'b1;
        endcase
      end
      if (wr_en & pready_out)
      begin
        case (paddr_in)
          `ADDR_ASSIGN: port_e_assign_register <= pwdata_in[7:0];
          `ADDR_DIVIDER: div_r <= pwdata_in[7:0];
          `ADDR_PORTE: {porte_dir_r, porte_data_r} <= pwdata_in[15:0];
          `ADDR_INTCTL: int_control_register <= pwdata_in[1:0];
          default: ;
        endcase
      end
    end
  end

  // Port A/B data kept apart so test register stays single driver
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ab_data_r <= 16'h0000;
      ab_dir_r <= 16'h0000;
    end
    else if (wr_en & pready_out & (paddr_in == `ADDR_TEST))
    begin
      {ab_dir_r, ab_data_r} <= pwdata_in;
    end
  end

  // ****************************************
  // Slow divider: toggle each div+1 cycles
  // ****************************************
  always @*
  begin
    div_cnt_nxt = (div_cnt_r >= div_r) ? 8'h00 : div_cnt_r + 8'h01;
  end

  // Toggling keeps duty exactly half for every setting
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      div_cnt_r <= 8'h00;
      slow_divider_clock <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_cnt_nxt;
      if (div_cnt_r >= div_r)
        slow_divider_clock <= ~slow_divider_clock;
    end
  end

  // ****************************************
  // Reset pin sequencing and mode capture
  // ****************************************
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rst_cnt_r <= 5'h00;
      rst_drive_r <= 1'b0;
      in_reset_r <= 1'b1;
      mode_r <= 3'h0;
    end
    else
    begin
      if (watchdog_timer_reset_in | clock_monitor_reset_in)
      begin
        rst_drive_r <= 1'b1;
        rst_cnt_r <= 5'h00;
        in_reset_r <= 1'b1;
      end
      else if (rst_drive_r)
      begin
        rst_cnt_r <= rst_cnt_r + 5'h01;
        if (rst_cnt_r == `RST_DRIVE_CYCLES)
        begin
          rst_drive_r <= 1'b0;
          rst_cnt_r <= 5'h00;
        end
      end
      else if (~reset_pin_in)
      begin
        in_reset_r <= 1'b1;
        rst_cnt_r <= 5'h00;
      end
      else if (in_reset_r)
      begin
        rst_cnt_r <= rst_cnt_r + 5'h01;
        if (rst_cnt_r == `RST_SAMPLE_CYCLES)
          in_reset_r <= 1'b0;
      end
      if (in_reset_r)
        mode_r <= {~special_mode_select_n_in, mode_pin_b_in,
          mode_pin_a_in};
    end
  end

  // ****************************************
  // Interrupt request sensing
  // ****************************************
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      irq_d_r <= 1'b1;
      int_pending_out <= 1'b0;
    end
    else
    begin
      irq_d_r <= int_request_n_in;
      if (~int_control_register[`BIT_IRQ_EN])
        int_pending_out <= 1'b0;
      else if (int_control_register[`BIT_IRQ_EDGE])
        int_pending_out <= irq_d_r & ~int_request_n_in;
      else
        int_pending_out <= ~int_request_n_in;
    end
  end

  // ****************************************
  // Pin function outputs
  // ****************************************
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_out <= 1'b0;
      pe7_out <= 1'b0;
      pe7_oe_out <= 1'b0;
      pe6_out <= 1'b0;
      pe6_oe_out <= 1'b0;
      mode_pins_out <= 2'h0;
      mode_pins_oe_out <= 1'b0;
      low_byte_strobe_out <= 1'b1;
      strobe_oe_out <= 1'b0;
      rdwr_out <= 1'b1;
      rdwr_oe_out <= 1'b0;
      bus_e_clock_out <= 1'b0;
      port_ab_out <= 16'h0000;
      port_ab_oe_out <= 16'h0000;
      bus_rdata_out <= 16'h0000;
      tag_high_input_out <= 1'b0;
      debug_select_out <= 1'b0;
      expanded_mode_out <= 1'b0;
      special_mode_out <= 1'b0;
    end
    else
    begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_out <= rst_drive_r;
      expanded_mode_out <= expanded;
      special_mode_out <= mode_r[2];
      // Pin serves debug in special, tag input otherwise
      debug_select_out <= mode_r[2] & ~in_reset_r;
      tag_high_input_out <= ~mode_r[2] & ~in_reset_r &
        special_mode_select_n_in;
      if (data_bus_enable_out)
      begin
        // Low while E high on enabled reads, gating external read drivers
        pe7_out <= ~(bus_enable_int_in & e_clock_in & bus_read_in);
        pe7_oe_out <= 1'b1;
      end
      else if (trim_reference_enable)
      begin
        pe7_out <= slow_divider_clock;
        pe7_oe_out <= 1'b1;
      end
      else
      begin
        pe7_out <= porte_data_r[7];
        pe7_oe_out <= porte_dir_r[7];
      end
      if (clock_test_enable & ~queue_track_enable)
      begin
        pe6_out <= test_clock_in;
        pe6_oe_out <= 1'b1;
      end
      else
      begin
        pe6_out <= porte_data_r[6];
        pe6_oe_out <= porte_dir_r[6];
      end
      if (queue_track_enable)
      begin
        mode_pins_out <= queue_state_in;
        mode_pins_oe_out <= 1'b1;
      end
      else
      begin
        mode_pins_out <= porte_data_r[5:4];
        mode_pins_oe_out <= porte_dir_r[5];
      end
      if (port_e_assign_register[`BIT_STROBE_EN])
      begin
        low_byte_strobe_out <= ~(addr0_in ^ access_size_flag_in);
        strobe_oe_out <= 1'b1;
      end
      else
      begin
        low_byte_strobe_out <= porte_data_r[3];
        strobe_oe_out <= porte_dir_r[3];
      end
      if (expanded & port_e_assign_register[`BIT_RDWR_EN])
      begin
        rdwr_out <= bus_read_in;
        rdwr_oe_out <= 1'b1;
      end
      else
      begin
        rdwr_out <= porte_data_r[2];
        rdwr_oe_out <= porte_dir_r[2];
      end
      bus_e_clock_out <= e_clock_in;
      if (expanded)
      begin
        // Address in E low, write data in E high
        port_ab_out <= e_clock_in ? bus_wdata_in : bus_addr_in;
        port_ab_oe_out <= {16{~(e_clock_in & bus_read_in)}};
        bus_rdata_out <= port_ab_in;
      end
      else
      begin
        port_ab_out <= ab_data_r;
        port_ab_oe_out <= ab_dir_r;
        bus_rdata_out <= 16'h0000;
      end
    end
  end

endmodule // bus_control_pin_function_mux
`default_nettype wire

/* File: verif/pin_mux_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.vh"
module pin_mux_checker (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Internal sources
  input wire logic e_clock_in,
  input wire logic bus_enable_int_in,
  input wire logic addr0_in,
  input wire logic access_size_flag_in,
  input wire logic bus_read_in,
  input wire logic test_clock_in,
  input wire logic watchdog_timer_reset_in,
  input wire logic clock_monitor_reset_in,
  // Pins
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_out,
  input wire logic expanded_mode_out,
  input wire logic pe7_out,
  input wire logic pe6_out,
  input wire logic pe6_oe_out,
  input wire logic low_byte_strobe_out,
  input wire logic strobe_oe_out,
  input wire logic bus_e_clock_out
);
  // ****
  // Shadow of the assignment register, aligned to the pins
  // ****
  logic [7:0] a_r;
  logic [7:0] q_r;
  always @(posedge clock_in or posedge reset_in)
    if (reset_in)
    begin
      a_r <= 8'h00;
      q_r <= 8'h00;
    end
    else
    begin
      if (psel_in && penable_in && pready_out && pwrite_in &&
          paddr_in == `ADDR_ASSIGN)
        a_r <= pwdata_in[7:0];
      q_r <= a_r;
    end
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  chk_strobe_xnor: assert property (strobe_oe_out &&
    $past(strobe_oe_out) |->
    low_byte_strobe_out == ($past(addr0_in) ~^ $past(access_size_flag_in)))
    else $error("strobe mismatch");
  chk_bus_e_clock_copy: assert property (!$past(reset_in) |->
    bus_e_clock_out == $past(e_clock_in)) else $error("bus_e_clock mismatch");
  chk_test_clock: assert property (q_r[5] && !q_r[4] &&
    $past(q_r[5] && !q_r[4]) |-> pe6_out == $past(test_clock_in))
    else $error("test clock mismatch");
  chk_queue_block: assert property (q_r[4] && $past(q_r[4]) |->
    !pe6_oe_out) else $error("test clock not blocked");
  chk_dbe_follow: assert property (expanded_mode_out &&
    !q_r[7] |-> pe7_out == !($past(bus_enable_int_in) &&
    $past(e_clock_in) && $past(bus_read_in)))
    else $error("bus enable not on pin");
  chk_reset_drive: assert property (
    $rose(watchdog_timer_reset_in) ||
    $rose(clock_monitor_reset_in) |-> ##[1:3] reset_pin_oe_out [*8])
    else $error("reset pin not driven");
  chk_reset_low: assert property (reset_pin_oe_out |->
    !reset_pin_out) else $error("reset pin driven high");
  chk_apb_ready: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready");
  chk_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
endmodule // pin_mux_checker
`default_nettype wire

/* File: verif/ext_bus_memory.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_bus_memory (
  // Clock
  input wire logic clock_in,
  // Bus
  input wire logic [15:0] port_ab_oe_out,
  input wire logic [15:0] data_in,
  output logic [15:0] port_ab_in
);
  logic [15:0] last_r;
  always @(posedge clock_in)
    last_r <= port_ab_in;
  // Drives only while the device has released the bus; else junk
  assign port_ab_in = (|port_ab_oe_out) ? ~last_r : data_in;
endmodule // ext_bus_memory
`default_nettype wire

/* File: verif/bus_control_pin_function_mux_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.vh"
module bus_control_pin_function_mux_tb_top;
  logic clock_in = 0, reset_in = 1, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, e_clock_in = 0, bus_enable_int_in = 0, addr0_in = 0;
  logic access_size_flag_in = 0, bus_read_in = 0, test_clock_in = 0;
  logic watchdog_timer_reset_in = 0, clock_monitor_reset_in = 0, err;
  logic int_request_n_in = 1, mode_pin_a = 1, special_mode_select_n = 1;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, rd;
  logic [15:0] mem_data = 16'ha5c3;
  logic [15:0] bus_addr_in = 16'h1234, bus_wdata_in = 16'h5678;
  logic [1:0] queue_state_in = 2'h2;
  wire logic [31:0] prdata_out;
  wire logic [15:0] port_ab_oe_out, port_ab_in, bus_rdata_out, port_ab_out;
  wire logic [1:0] mode_pins_out;
  wire logic tag_high_input_out, debug_select_out;
  wire logic pready_out, pslverr_out, reset_pin_in, reset_pin_out;
  wire logic reset_pin_oe_out, int_pending_out, expanded_mode_out, pe7_out;
  wire logic special_mode_out, pe7_oe_out, pe6_out, pe6_oe_out, rdwr_out;
  wire logic mode_pins_oe_out, low_byte_strobe_out, strobe_oe_out;
  wire logic rdwr_oe_out, bus_e_clock_out;
  integer num_errors = 0, total_checks = 0, i, k, n, h, t;
  logic p;
  bus_control_pin_function_mux uut (.clock_in, .reset_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .e_clock_in, .bus_enable_int_in, .addr0_in,
    .access_size_flag_in, .bus_read_in, .bus_addr_in, .bus_wdata_in,
    .test_clock_in, .queue_state_in,
    .watchdog_timer_reset_in, .clock_monitor_reset_in, .reset_pin_in,
    .reset_pin_out, .reset_pin_oe_out, .int_request_n_in, .int_pending_out,
    .mode_pin_a_in(mode_pin_a), .mode_pin_b_in(1'b0),
    .special_mode_select_n_in(special_mode_select_n),
    .tag_high_input_out, .debug_select_out, .expanded_mode_out,
    .special_mode_out, .pe7_out, .pe7_oe_out, .pe6_out, .pe6_oe_out,
    .mode_pins_out, .mode_pins_oe_out, .low_byte_strobe_out, .strobe_oe_out,
    .rdwr_out, .rdwr_oe_out, .bus_e_clock_out, .port_ab_out,
    .port_ab_oe_out, .port_ab_in, .bus_rdata_out);
  ext_bus_memory mem (.clock_in, .port_ab_oe_out, .data_in(mem_data),
    .port_ab_in);
  // Reset pin has a pull-up when nobody drives it
  assign reset_pin_in = reset_pin_oe_out ? reset_pin_out : 1'b1;
  initial
    forever #5 clock_in = ~clock_in;
  always @(posedge clock_in)
    e_clock_in <= ~e_clock_in;
  task print_verdict;
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(posedge clock_in);
  endtask
  // ****
  // APB transfer; the leading edge keeps psel from toggling twice at once
  // ****
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer c;
    c = 0;
    @(posedge clock_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1;
    do
    begin
      @(posedge clock_in);
      c++;
    end
    while (pready_out !== 1'b1 && c < 20);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    if (c == 20)
    begin
      num_errors++;
      print_verdict;
    end
  endtask
  task t_reset;
    check(low_byte_strobe_out, 1, "strobe_rst");
    check(rdwr_out, 1, "rdwr_rst");
    check(pe7_oe_out, 0, "pe7_oe_rst");
    reset_in <= 0;
    cyc(15);
    check(expanded_mode_out, 1, "expanded");
    check(special_mode_out, 0, "special");
    check(tag_high_input_out, 1, "tag_high");
    check(debug_select_out, 0, "debug_sel");
    check(pe7_oe_out, 1, "dbe_rst");
    apb(0, `ADDR_MODE, 0);
    check(rd[2:0], 3'h1, "mode_reg");
    apb(0, `ADDR_INTCTL, 0);
    check(rd, `INTCTL_RESET, "intctl");
    apb(0, 12'h0f0, 0);
    check(err, 1, "unmapped");
    int_request_n_in <= 0;
    cyc(4);
    check(int_pending_out, 1, "irq_level");
    int_request_n_in <= 1;
    // Edge mode: one falling edge gives exactly one pending cycle
    apb(1, `ADDR_INTCTL, 32'h3);
    int_request_n_in <= 0;
    n = 0;
    for (i = 0; i < 6; i++)
    begin
      @(posedge clock_in);
      n += (int_pending_out === 1'b1);
    end
    check(n, 1, "irq_edge");
    int_request_n_in <= 1;
  endtask
  task t_strobe;
    bus_read_in <= 1;
    apb(1, `ADDR_ASSIGN, 32'h0c);
    for (i = 0; i < 4; i++)
    begin
      @(posedge clock_in);
      addr0_in <= i[0];
      access_size_flag_in <= i[1];
      cyc(2);
      check(low_byte_strobe_out, (i[0] == i[1]), "strobe");
    end
    check(rdwr_oe_out, 1, "rdwr_oe");
    check(rdwr_out, 1, "rdwr");
    // Read data lands two edges after an E-high sample
    @(posedge clock_in);
    if (e_clock_in !== 1'b1)
      @(posedge clock_in);
    check(bus_rdata_out, mem_data, "bus_read");
    check(port_ab_out, 16'h1234, "bus_addr");
    check(port_ab_oe_out, 16'hffff, "addr_drive");
    @(posedge clock_in);
    check(port_ab_oe_out, 16'h0000, "read_release");
  endtask
  task t_cal;
    for (k = 0; k < 3; k++)
    begin
      apb(1, `ADDR_DIVIDER, 2 ** k - 1);
      apb(1, `ADDR_ASSIGN, 32'hc0);
      cyc(4);
      h = 0;
      t = 0;
      p = pe7_out;
      for (i = 0; i < 24; i++)
      begin
        @(posedge clock_in);
        h += pe7_out;
        t += (pe7_out !== p);
        p = pe7_out;
      end
      check(h, 12, "cal_duty");
      check(t, 24 >> k, "cal_rate");
    end
    apb(1, `ADDR_ASSIGN, 32'h80);
    cyc(3);
    check(pe7_oe_out, 0, "cal_off");
  endtask
  task t_dbe;
    apb(1, `ADDR_ASSIGN, 32'h40);
    cyc(3);
    check(pe7_out, 1, "dbe_idle");
    bus_enable_int_in <= 1;
    cyc(2);
    // Pin shows the E phase of one edge earlier
    if (e_clock_in !== 1'b0)
      @(posedge clock_in);
    check(pe7_out, 0, "dbe_low");
    @(posedge clock_in);
    check(pe7_out, 1, "dbe_high");
    check(pe7_oe_out, 1, "dbe_oe");
  endtask
  task t_ctest;
    apb(1, `ADDR_ASSIGN, 32'ha0);
    for (i = 0; i < 4; i++)
    begin
      @(posedge clock_in);
      test_clock_in <= i[0];
      cyc(2);
      check(pe6_out, i[0], "test_clk");
    end
    check(mode_pins_oe_out, 0, "queue_off");
    apb(1, `ADDR_ASSIGN, 32'hb0);
    cyc(3);
    check(pe6_oe_out, 0, "test_blocked");
    check(mode_pins_out, 2'h2, "queue_track");
    check(mode_pins_oe_out, 1, "queue_oe");
  endtask
  task t_wdog;
    for (k = 0; k < 2; k++)
    begin
      @(posedge clock_in);
      watchdog_timer_reset_in <= (k == 0);
      clock_monitor_reset_in <= (k == 1);
      @(posedge clock_in);
      watchdog_timer_reset_in <= 0;
      clock_monitor_reset_in <= 0;
      n = 0;
      for (i = 0; i < 60; i++)
      begin
        @(posedge clock_in);
        n += (reset_pin_oe_out === 1'b1);
      end
      check(n == 16 || n == 17, 1, "reset_drive");
    end
  endtask
  initial
  begin
    repeat (10) @(posedge clock_in);
    t_reset;
    t_strobe;
    t_cal;
    t_dbe;
    t_ctest;
    t_wdog;
    print_verdict;
  end
endmodule // bus_control_pin_function_mux_tb_top
bind bus_control_pin_function_mux pin_mux_checker chk (.clock_in, .reset_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out,
  .pslverr_out, .e_clock_in, .bus_enable_int_in, .addr0_in,
  .access_size_flag_in, .bus_read_in, .test_clock_in,
  .watchdog_timer_reset_in,
  .clock_monitor_reset_in, .reset_pin_out, .reset_pin_oe_out,
  .expanded_mode_out, .pe7_out, .pe6_out, .pe6_oe_out, .low_byte_strobe_out,
  .strobe_oe_out, .bus_e_clock_out);
`default_nettype wire
